// file: design/i2c_pkg.sv
// Constants shared by the two-wire bus controller and its pin synchroniser.
// Assumes a 200 MHz system clock and an APB register bus with byte offsets.
package i2c_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] DATA_OFS = 8'h08;
	localparam logic [7:0] ADDR_OFS = 8'h0c;
	localparam logic [7:0] DIV_OFS = 8'h10;

	// Control register bit positions.
	localparam int C_EN = 7;
	localparam int C_IE = 6;
	localparam int C_MS = 5;
	localparam int C_TX = 4;
	localparam int C_TRANSMIT_ACK_CONTROL = 3;
	localparam int C_RS = 2;

	// Status register bit positions.
	localparam int S_ICF = 7;
	localparam int S_AAS = 6;
	localparam int S_BB = 5;
	localparam int S_AL = 4;
	localparam int S_SRW = 2;
	localparam int S_IIF = 1;
	localparam int S_RECEIVED_ACK_FLAG = 0;

	// Values after reset.
	localparam logic [7:0] DIV_RST = 8'h3f;
	localparam logic [6:0] OWN_RST = 7'h00;
	localparam logic ICF_RST = 1'b1;

	// Bit count at which the acknowledge slot begins.
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	// Bit count held from START until the clock first falls.
	localparam logic [3:0] PRE_BIT = 4'hf;

	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_START = 3'b001,
		M_HOLD = 3'b010,
		M_RUN = 3'b011,
		M_RS1 = 3'b100,
		M_RS2 = 3'b101,
		M_STOP1 = 3'b110,
		M_STOP2 = 3'b111
	} mst_t;

endpackage : i2c_pkg

// file: design/pin_sync.sv
// Three-stage synchroniser with agreement filter for one bus pin.
// Assumes the pin is asynchronous to clk; the output moves only when the
// second and third stages agree.
`timescale 1ns/1ps
module pin_sync
#(
	parameter int RST_VAL = 1
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin and filtered level
	input wire logic pin,
	output logic lvl
);
	import i2c_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic v;
	} sync_t;

	sync_t q;
	sync_t d;

	if (RST_VAL != 0 && RST_VAL != 1)
	begin : g_chk
		$error("pin_sync: RST_VAL must be 0 or 1");
	end

	always_comb
	begin
		d = q;
		d.s1 = pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (q.s2 == q.s3)
		begin
			d.v = q.s3;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			q <= {4{RST_VAL[0]}};
		end
		else
		begin
			q <= d;
		end
	end

	assign lvl = q.v;

endmodule : pin_sync

// file: design/i2c_port.sv
// Status, data and bus engine of a two-wire master/slave controller.
// Assumes an APB master on one side and open-drain bus wires on the other.
//
// Functional notes
// - Byte-complete low while shifting; set at ninth clock falling edge.
// - Addressed-as-slave set when received address equals own address.
// - A control register write clears addressed-as-slave, except in a cycle with an address match.
// - Bus-busy set on START, cleared on any STOP.
// - Arbitration lost when driving high in a transmit bit, seeing low.
// - Arbitration lost when master receiver's high ack reads low.
// - Arbitration lost when START is requested on a busy bus.
// - Arbitration lost when repeated START is requested in slave mode.
// - Arbitration lost on a STOP that our master did not request.
// - Arbitration-lost stays set until software writes zero.
// - Slave-direction shows the read/write bit of matched address.
// - Slave-direction valid only after complete transfer while addressed.
// - Interrupt-pending set on byte done, address match, arbitration loss.
// - Interrupt request raised while pending and enable bit set.
// - Received-ack captures data line level in the acknowledge bit.
// - Master transmit: data write starts a byte, MSB first.
// - Master receive: data read returns byte, starts next reception.
// - Slave data read/write functions only after own address matched.
// - Master-select makes START; repeat-start makes restart when owner.
// - On arbitration loss drop master-select, no STOP generated.
// - Data receiver acks when transmit-ack control is zero, else releases; a matched own address is always acked.
`timescale 1ns/1ps
module i2c_port
#(
	parameter int ADDR_W = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Bus clock wire
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	// Bus data wire
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Interrupt request
	output logic irq
);
	import i2c_pkg::*;

	if (ADDR_W < 5)
	begin : g_chk
		$error("i2c_port: ADDR_W too small for the register map");
	end

	typedef struct packed {
		logic ien;
		logic iie;
		logic master_select_bit;
		logic mtx;
		logic transmit_ack_control;
		logic [6:0] own;
		logic [7:0] div;
		logic [7:0] dcnt;
		logic byte_complete_flag;
		logic addressed_as_slave_flag;
		logic bus_busy_flag;
		logic arbitration_lost_flag;
		logic slave_direction_flag;
		logic interrupt_pending_flag;
		logic received_ack_flag;
		logic [7:0] data;
		logic [7:0] sh;
		logic [3:0] bits;
		logic inbyte;
		logic addr_ph;
		logic slv;
		logic hold;
		logic stop_req;
		mst_t mst;
		logic scl_low;
		logic sda_low;
		logic sclp;
		logic sdap;
		logic lo;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} state_t;

	state_t q;
	state_t d;
	logic scl_s;
	logic sda_s;
	logic scl_r;
	logic scl_f;
	logic st_det;
	logic sp_det;
	logic tx;
	logic act;
	logic acc;
	logic [7:0] ofs;
	logic [7:0] w;
	logic wr_ctrl;
	logic wr_stat;
	logic match_ev;

	////////////////////////////////////////////////////////////////////////
	pin_sync #(.RST_VAL(1)) u_scl (
		.clk(clk),
		.rst(rst),
		.pin(scl_in),
		.lvl(scl_s)
	);

	pin_sync #(.RST_VAL(1)) u_sda (
		.clk(clk),
		.rst(rst),
		.pin(sda_in),
		.lvl(sda_s)
	);

	assign scl_r = scl_s & ~q.sclp;
	assign scl_f = ~scl_s & q.sclp;
	// Data moving while the clock stays high marks START or STOP.
	assign st_det = q.sdap & ~sda_s & scl_s & q.sclp;
	assign sp_det = ~q.sdap & sda_s & scl_s & q.sclp;
	// The address byte is always received when we are not the master.
	assign tx = q.mtx & ~(q.addr_ph & ~q.master_select_bit);
	assign act = q.inbyte & (q.master_select_bit | q.slv | q.addr_ph) & q.ien;
	assign acc = psel & penable & q.pready;
	assign ofs = 8'(paddr);
	assign w = pwdata[7:0];
	assign wr_ctrl = acc & pwrite & (ofs == CTRL_OFS);
	assign wr_stat = acc & pwrite & (ofs == STAT_OFS);
	assign match_ev = scl_f & act & q.addr_ph & ~q.master_select_bit
		& (q.bits == LAST_BIT) & (q.sh[7:1] == q.own);

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		d.sclp = scl_s;
		d.sdap = sda_s;
		if (q.dcnt == 8'h00)
		begin
			d.dcnt = q.div;
		end
		else
		begin
			d.dcnt = q.dcnt - 8'h01;
		end

		// Setup phase: answer in the following access cycle.
		if (psel && !penable)
		begin
			d.pready = 1'b1;
			d.prdata = 32'h0;
			case (ofs)
				CTRL_OFS: d.prdata[7:0] = {q.ien, q.iie, q.master_select_bit, q.mtx,
					q.transmit_ack_control, 3'b000};
				STAT_OFS: d.prdata[7:0] = {q.byte_complete_flag, q.addressed_as_slave_flag, q.bus_busy_flag, q.arbitration_lost_flag,
					1'b0, q.slave_direction_flag, q.interrupt_pending_flag, q.received_ack_flag};
				DATA_OFS: d.prdata[7:0] = q.data;
				ADDR_OFS: d.prdata[7:0] = {q.own, 1'b0};
				DIV_OFS: d.prdata[7:0] = q.div;
				default: d.pslverr = 1'b1;
			endcase
		end

		// Software effects come first so hardware events below win.
		if (wr_ctrl)
		begin
			d.ien = w[C_EN];
			d.iie = w[C_IE];
			d.mtx = w[C_TX];
			d.transmit_ack_control = w[C_TRANSMIT_ACK_CONTROL];
			d.addressed_as_slave_flag = 1'b0;
			if (!q.master_select_bit && w[C_MS])
			begin
				if (q.bus_busy_flag)
				begin
					d.arbitration_lost_flag = 1'b1;
					d.interrupt_pending_flag = 1'b1;
				end
				else
				begin
					d.master_select_bit = 1'b1;
					d.mst = M_START;
				end
			end
			else if (q.master_select_bit && !w[C_MS])
			begin
				d.master_select_bit = 1'b0;
				d.stop_req = 1'b1;
				d.mst = M_STOP1;
			end
			else if (w[C_RS])
			begin
				if (q.master_select_bit)
				begin
					d.mst = M_RS1;
				end
				else
				begin
					d.arbitration_lost_flag = 1'b1;
					d.interrupt_pending_flag = 1'b1;
				end
			end
		end
		if (wr_stat)
		begin
			d.arbitration_lost_flag = q.arbitration_lost_flag & w[S_AL];
			d.interrupt_pending_flag = q.interrupt_pending_flag & w[S_IIF];
		end
		if (acc && pwrite && ofs == ADDR_OFS)
		begin
			d.own = w[7:1];
		end
		if (acc && pwrite && ofs == DIV_OFS)
		begin
			d.div = w;
		end
		if (acc && ofs == DATA_OFS && (q.master_select_bit || q.slv))
		begin
			if (pwrite && tx)
			begin
				d.data = w;
				d.sh = w;
				d.byte_complete_flag = 1'b0;
				d.hold = 1'b0;
				if (q.mst == M_HOLD || (!q.master_select_bit && q.hold))
				begin
					d.sda_low = ~w[7];
				end
				if (q.mst == M_HOLD)
				begin
					d.mst = M_RUN;
				end
			end
			else if (!pwrite && !tx)
			begin
				// Each read, the first a dummy one, releases the next byte.
				d.byte_complete_flag = 1'b0;
				d.hold = 1'b0;
				if (q.mst == M_HOLD)
				begin
					d.mst = M_RUN;
				end
			end
		end

		////////////////////////////////////////////////////////////////////
		// Master clock and condition generation on divider ticks.
		if (q.dcnt == 8'h00)
		begin
			case (q.mst)
				M_START:
				begin
					if (!q.sda_low && scl_s)
					begin
						d.sda_low = 1'b1;
					end
					else if (q.sda_low)
					begin
						d.scl_low = 1'b1;
						d.mst = M_HOLD;
					end
				end
				M_RUN:
				begin
					// Release only after our own fall has been seen, so the
					// next data bit is on the wire before the clock rises.
					if (q.scl_low)
					begin
						if (!scl_s && !q.sclp)
						begin
							d.scl_low = 1'b0;
						end
					end
					else if (scl_s)
					begin
						d.scl_low = 1'b1;
					end
				end
				M_RS1:
				begin
					d.sda_low = 1'b0;
					d.mst = M_RS2;
				end
				M_RS2:
				begin
					d.scl_low = 1'b0;
					d.mst = M_START;
				end
				M_STOP1:
				begin
					d.sda_low = 1'b1;
					d.mst = M_STOP2;
				end
				M_STOP2:
				begin
					if (q.scl_low)
					begin
						d.scl_low = 1'b0;
					end
					else if (scl_s)
					begin
						d.sda_low = 1'b0;
						d.mst = M_IDLE;
					end
				end
				default:
				begin
				end
			endcase
		end

		////////////////////////////////////////////////////////////////////
		// Bus observation: every participant shifts on the same edges.
		if (q.ien && st_det)
		begin
			d.bus_busy_flag = 1'b1;
			d.bits = PRE_BIT;
			d.inbyte = 1'b1;
			d.addr_ph = 1'b1;
			d.byte_complete_flag = 1'b0;
			d.slv = 1'b0;
			d.hold = 1'b0;
		end
		if (q.ien && sp_det)
		begin
			d.bus_busy_flag = 1'b0;
			d.inbyte = 1'b0;
			d.addr_ph = 1'b0;
			d.slv = 1'b0;
			d.hold = 1'b0;
			d.stop_req = 1'b0;
			if (q.master_select_bit && !q.stop_req)
			begin
				d.arbitration_lost_flag = 1'b1;
				d.interrupt_pending_flag = 1'b1;
				d.master_select_bit = 1'b0;
				d.mst = M_IDLE;
				d.scl_low = 1'b0;
				d.sda_low = 1'b0;
			end
		end
		if (scl_r && act)
		begin
			if (q.bits != ACK_BIT)
			begin
				d.sh = {q.sh[6:0], sda_s};
			end
			else
			begin
				d.received_ack_flag = sda_s;
			end
			// A released line read low means another master won.
			if (q.master_select_bit && !q.sda_low && !sda_s
				&& (q.bits == ACK_BIT ? !tx : tx))
			begin
				d.arbitration_lost_flag = 1'b1;
				d.interrupt_pending_flag = 1'b1;
				d.master_select_bit = 1'b0;
				d.mst = M_IDLE;
				d.scl_low = 1'b0;
				d.sda_low = 1'b0;
			end
		end
		if (scl_f && act)
		begin
			if (q.bits == LAST_BIT)
			begin
				d.bits = ACK_BIT;
				if (q.addr_ph && !q.master_select_bit)
				begin
					if (match_ev)
					begin
						d.slv = 1'b1;
						d.addressed_as_slave_flag = 1'b1;
						d.slave_direction_flag = q.sh[0];
						d.sda_low = 1'b1;
					end
					else
					begin
						d.inbyte = 1'b0;
						d.addr_ph = 1'b0;
					end
				end
				else
				begin
					d.sda_low = ~tx & ~q.transmit_ack_control;
				end
			end
			else if (q.bits == ACK_BIT)
			begin
				d.byte_complete_flag = 1'b1;
				d.interrupt_pending_flag = 1'b1;
				d.bits = 4'h0;
				d.addr_ph = 1'b0;
				d.hold = 1'b1;
				d.sda_low = 1'b0;
				if (!tx)
				begin
					d.data = q.sh;
				end
				if (q.master_select_bit)
				begin
					d.mst = M_HOLD;
				end
			end
			else if (q.bits == PRE_BIT)
			begin
				// The fall that follows START opens the first bit cell.
				d.bits = 4'h0;
			end
			else
			begin
				d.bits = q.bits + 4'h1;
				d.sda_low = tx & ~q.sh[7];
			end
		end

		// A slave stretches the clock until software serves the byte.
		if (!d.master_select_bit && d.mst == M_IDLE)
		begin
			d.scl_low = d.hold & d.slv;
		end
		if (!d.ien)
		begin
			d.master_select_bit = 1'b0;
			d.mst = M_IDLE;
			d.scl_low = 1'b0;
			d.sda_low = 1'b0;
			d.inbyte = 1'b0;
			d.slv = 1'b0;
			d.hold = 1'b0;
		end
		d.irq = d.interrupt_pending_flag & d.iie;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			q <= '0;
			q.div <= DIV_RST;
			q.own <= OWN_RST;
			q.byte_complete_flag <= ICF_RST;
			q.mst <= M_IDLE;
		end
		else
		begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign scl_out = q.lo;
	assign scl_oe = q.scl_low;
	assign sda_out = q.lo;
	assign sda_oe = q.sda_low;
	assign irq = q.irq;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_icf_ninth: assert property (scl_f && act && q.bits == ACK_BIT
		|=> q.byte_complete_flag) else $error("byte complete not set");
	a_icf_shifting: assert property (act && q.bits != 4'h0 |-> !q.byte_complete_flag)
		else $error("byte complete high mid byte");
	a_addressed_as_slave_flag_ctrl_clr: assert property (wr_ctrl && !match_ev |=> !q.addressed_as_slave_flag)
		else $error("slave flag survived control write");
	a_busy_start: assert property (q.ien && st_det && !sp_det
		|=> q.bus_busy_flag) else $error("busy not set on start");
	a_al_busy_start: assert property (wr_ctrl && w[C_MS] && !q.master_select_bit
		&& q.bus_busy_flag |=> q.arbitration_lost_flag) else $error("busy start not lost");
	a_al_sticky: assert property (q.arbitration_lost_flag && !(wr_stat && !w[S_AL])
		|=> q.arbitration_lost_flag) else $error("arbitration flag dropped");
	a_irq_gate: assert property (q.interrupt_pending_flag && q.iie |-> irq)
		else $error("interrupt not raised");
	a_received_ack_flag_cap: assert property (scl_r && act && q.bits == ACK_BIT
		|=> q.received_ack_flag == $past(sda_s)) else $error("ack not captured");
	a_ack_drive: assert property (scl_f && act && q.bits == LAST_BIT
		&& !tx && !q.addr_ph && !q.transmit_ack_control |=> q.sda_low)
		else $error("receiver did not ack");

	c_start: cover property (st_det);
	c_match: cover property (match_ev);
	c_byte: cover property (scl_f && act && q.bits == ACK_BIT);
	c_lost: cover property ($rose(q.arbitration_lost_flag));

endmodule : i2c_port

// file: verification/bus_peer.sv
// Behavioural far-side target: acknowledges one address, keeps the last
// byte written to it. Assumes resolved wires with pull-ups.
`timescale 1ns/1ps
module bus_peer
#(
	parameter logic [6:0] ADDR = 7'h2a
)
(
	// Resolved bus wires
	input wire logic scl,
	input wire logic sda,
	// Pull-down enable on the data wire
	output logic sda_oe,
	// Last data byte received while selected
	output logic [7:0] rx_byte
);
	logic [7:0] sh;
	logic sel;
	int cnt;

	initial
	begin
		sda_oe = 1'h0;
		rx_byte = 8'h00;
		sh = 8'h00;
		sel = 1'h0;
		cnt = -1;
	end
	always @(negedge sda)
		if (scl === 1'h1)
		begin
			cnt = 0;
			sel = 1'h0;
		end
	always @(posedge sda)
		if (scl === 1'h1)
			cnt = -1;
	always @(posedge scl)
		if (cnt >= 0 && cnt < 8)
		begin
			sh = {sh[6:0], sda};
			cnt++;
		end
	// The acknowledge moves only while the clock is low, so it can never
	// look like a start or a stop to anyone on the wire.
	always @(negedge scl)
		if (cnt == 9)
		begin
			sda_oe = 1'h0;
			cnt = sel ? 0 : -1;
		end
		else if (cnt == 8)
		begin
			if (sel)
				rx_byte = sh;
			sel = sel | (sh[7:1] == ADDR);
			sda_oe = sel;
			cnt = 9;
		end
endmodule : bus_peer

// file: verification/test_i2c_status_and_data_port.sv
// Self-checking bench for the two-wire status and data port.
// Assumes bus_peer answers at 7'h2a; the bench plays a second master.
`timescale 1ns/1ps
module test_i2c_status_and_data_port
	import i2c_pkg::*;
;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, s;
	logic scl_out, scl_oe, sda_out, sda_oe, peer_oe, ext_scl, ext_sda;
	logic [7:0] paddr, peer_byte, r;
	logic [31:0] pwdata, prdata;
	int mismatches, samples_checked;
	localparam logic [7:0] SELF_CALL = 8'h66;
	wire scl = ~(scl_oe | ext_scl);
	wire sda = ~(sda_oe | peer_oe | ext_sda);

	i2c_port #(.ADDR_W(8)) DUT (.clk(clk), .rst(rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
	bus_peer #(.ADDR(7'h2a)) peer (.scl(scl), .sda(sda), .sda_oe(peer_oe),
		.rx_byte(peer_byte));

	initial
	begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'h1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		r = prdata[7:0];
		s = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n == 20)
			mismatches++;
	endtask : apb
	task automatic poll(input logic [7:0] m, input logic [7:0] v);
		int n;
		n = 0;
		do
		begin
			apb(1'h0, STAT_OFS, 8'h00);
			n++;
		end
		while ((r & m) !== v && n < 400);
		chk(r & m, v);
	endtask : poll
	// The bench master's clock runs at 160 ns, 32 system clocks.
	task automatic half();
		repeat (16) @(posedge clk);
	endtask : half
	task automatic ext_bit(input logic b);
		ext_sda <= ~b;
		half();
		ext_scl <= 1'h0;
		half();
		s = sda;
		ext_scl <= 1'h1;
	endtask : ext_bit
	task automatic ext_stop();
		int n;
		n = 0;
		ext_sda <= 1'h1;
		half();
		ext_scl <= 1'h0;
		while (scl !== 1'h1 && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		half();
		ext_sda <= 1'h0;
		half();
	endtask : ext_stop
	task automatic final_report();
		$display("compared %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////
	initial
	begin
		#400000;
		mismatches++;
		final_report();
	end
	initial
	begin
		{rst, psel, penable, pwrite, ext_scl, ext_sda} = 6'h20;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		mismatches = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		apb(1'h0, STAT_OFS, 8'h00);
		chk(r, 8'h80);
		apb(1'h0, DIV_OFS, 8'h00);
		chk(r, DIV_RST);
		apb(1'h0, 8'h14, 8'h00);
		chk({s, r[6:0]}, 8'h80);
		apb(1'h1, DIV_OFS, 8'h01);
		apb(1'h1, ADDR_OFS, 8'h66);
		apb(1'h1, CTRL_OFS, 8'hc0);
		// Another master holds the bus while software asks for a START.
		ext_sda <= 1'h1;
		half();
		poll(8'h20, 8'h20);
		apb(1'h1, CTRL_OFS, 8'he0);
		apb(1'h0, STAT_OFS, 8'h00);
		chk(r & 8'h7f, 8'h32);
		chk({7'h00, irq}, 8'h01);
		apb(1'h0, CTRL_OFS, 8'h00);
		chk(r & 8'h20, 8'h00);
		apb(1'h1, STAT_OFS, 8'h12);
		apb(1'h0, STAT_OFS, 8'h00);
		chk(r & 8'h12, 8'h12);
		apb(1'h1, STAT_OFS, 8'h00);
		apb(1'h0, STAT_OFS, 8'h00);
		chk(r & 8'h12, 8'h00);
		chk({7'h00, irq}, 8'h00);
		ext_sda <= 1'h0;
		half();
		poll(8'h30, 8'h00);
		// The bench master calls our own address for a write.
		ext_sda <= 1'h1;
		half();
		// Pull the clock low before the first data bit changes the wire.
		ext_scl <= 1'h1;
		half();
		for (int i = 7; i >= 0; i--)
			ext_bit(SELF_CALL[i]);
		ext_bit(1'h1);
		chk({7'h00, s}, 8'h00);
		poll(8'h02, 8'h02);
		chk(r, 8'he2);
		apb(1'h1, STAT_OFS, 8'h00);
		apb(1'h1, CTRL_OFS, 8'hc0);
		apb(1'h0, STAT_OFS, 8'h00);
		chk(r & 8'h42, 8'h00);
		apb(1'h0, DATA_OFS, 8'h00);
		ext_stop();
		poll(8'h30, 8'h00);
		// Own master writes the peer's address and one data byte.
		apb(1'h1, CTRL_OFS, 8'hf0);
		poll(8'h20, 8'h20);
		apb(1'h1, DATA_OFS, 8'h54);
		poll(8'h02, 8'h02);
		chk(r, 8'ha2);
		chk({7'h00, irq}, 8'h01);
		apb(1'h1, STAT_OFS, 8'h00);
		apb(1'h1, DATA_OFS, 8'ha5);
		apb(1'h0, STAT_OFS, 8'h00);
		chk(r & 8'h82, 8'h00);
		poll(8'h83, 8'h82);
		chk(peer_byte, 8'ha5);
		apb(1'h1, CTRL_OFS, 8'hc0);
		poll(8'h30, 8'h00);
		final_report();
	end
endmodule : test_i2c_status_and_data_port
